// ==== common/padc_regs.vh ====
// Purpose: Constants for the pipelined converter digital side
// Assumes: Included by bare name from rtl files
// Notes:   Register map offsets are byte addresses on the Avalon-MM bus
`ifndef PADC_REGS_VH
`define PADC_REGS_VH
`define PADC_DATA_W        10
`define PADC_LATENCY       5
`define PADC_STAGES        9
`define PADC_ADDR_W        4
`define PADC_OFS_CTRL      4'h0
`define PADC_OFS_STATUS    4'h4
`define PADC_OFS_SAMPLE    4'h8
`define PADC_OFS_ANALOG    4'hC
`define PADC_CTRL_OE_N     0
`define PADC_CTRL_SLEEP    1
`define PADC_CTRL_SPAN     2
`define PADC_CTRL_REFEXT   3
`define PADC_CTRL_RST      4'hC
`define PADC_UNMAPPED      32'hDEADBEEF
`define PADC_MIDSCALE      10'h200
`define PADC_VALID_W       3
`endif

// ==== rtl/padc_core.v ====
// Purpose: Digital side of a 10-bit pipelined sampling converter
// Assumes: core_clk is the convert clock; analog code arrives as a sampled word
// Notes:   Control pins are mirrored in a control register reached over Avalon-MM
`timescale 1ns/100ps
`default_nettype none
`include "padc_regs.vh"

module padc_core
#(
	parameter DATA_W  = `PADC_DATA_W,
	parameter LATENCY = `PADC_LATENCY
)
(
	input  wire                      core_clk,
	input  wire                      rst,
	input  wire [DATA_W-1:0]         analog_code,
	input  wire [`PADC_ADDR_W-1:0]   avs_address,
	input  wire                      avs_read,
	input  wire                      avs_write,
	input  wire [31:0]               avs_writedata,
	input  wire [3:0]                avs_byteenable,
	output reg  [31:0]               avs_readdata,
	output reg                       avs_waitrequest,
	output reg  [DATA_W-1:0]         sample_o,
	output reg  [DATA_W-1:0]         sample_oe_n,
	output reg                       sample_valid,
	output reg                       powered_down,
	output reg                       span_2v,
	output reg                       ref_external
);

	// ****************************************
	// Constants
	// ****************************************
	// Count at which the pipe holds only samples taken since the last wake
	localparam [`PADC_VALID_W-1:0] FILL_FULL = LATENCY;
	localparam [`PADC_VALID_W-1:0] FILL_ZERO = {`PADC_VALID_W{1'b0}};
	localparam [`PADC_VALID_W-1:0] FILL_STEP = {{(`PADC_VALID_W-1){1'b0}}, 1'b1};
	localparam [DATA_W-1:0]        CODE_MID  = `PADC_MIDSCALE;
	localparam [31-DATA_W:0]       RD_PAD    = {(32-DATA_W){1'b0}};
	localparam                     BUS_IDLE  = 1'b0;
	localparam                     BUS_ANSW  = 1'b1;

	// ****************************************
	// Declarations
	// ****************************************
	reg  [3:0]                ctrl_r;
	reg  [3:0]                ctrl_nxt;
	reg                       bus_state_r;
	reg                       bus_state_nxt;
	reg  [31:0]               rdata_nxt;
	reg  [`PADC_VALID_W-1:0]  fill_r;
	reg  [`PADC_VALID_W-1:0]  fill_nxt;
	wire                      bus_req;
	wire                      bus_take;
	wire                      ctrl_commit;
	wire                      pipe_adv;
	wire                      fill_done;
	wire [DATA_W*LATENCY-1:0] stage_bus;
	wire [DATA_W-1:0]         pipe_head;
	wire [DATA_W-1:0]         pipe_tail;

	// Control bits stand in for the static pins
	wire sleep_request           = ctrl_r[`PADC_CTRL_SLEEP];
	wire input_span_select       = ctrl_r[`PADC_CTRL_SPAN];
	wire reference_source_select = ctrl_r[`PADC_CTRL_REFEXT];
	wire output_tristate_n       = ctrl_r[`PADC_CTRL_OE_N];

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	// One wait cycle per access, so the master sees the answer on its second edge
	assign bus_req     = avs_read || avs_write;
	assign bus_take    = bus_req && (bus_state_r == BUS_IDLE);
	// The write lands on the edge that sees waitrequest low, never earlier
	assign ctrl_commit = avs_write && !avs_waitrequest && avs_byteenable[0]
		&& (avs_address == `PADC_OFS_CTRL);

	always @*
	begin
		bus_state_nxt = bus_state_r;
		case (bus_state_r)
			BUS_IDLE:
			begin
				if (bus_req)
					bus_state_nxt = BUS_ANSW;
			end
			BUS_ANSW:
			begin
				bus_state_nxt = BUS_IDLE;
			end
			default:
			begin
				bus_state_nxt = BUS_IDLE;
			end
		endcase
	end

	always @(posedge core_clk)
	begin
		if (rst)
			bus_state_r <= BUS_IDLE;
		else
			bus_state_r <= bus_state_nxt;
	end

	always @(posedge core_clk)
	begin
		if (rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= (bus_state_nxt != BUS_ANSW);
	end

	// Read data are chosen on the taking edge and stand until the next access
	always @*
	begin
		rdata_nxt = `PADC_UNMAPPED;
		if (avs_address == `PADC_OFS_CTRL)
			rdata_nxt = {28'h0, ctrl_r};
		else if (avs_address == `PADC_OFS_STATUS)
			rdata_nxt = {29'h0, sample_valid, powered_down, 1'b0};
		else if (avs_address == `PADC_OFS_SAMPLE)
			rdata_nxt = {RD_PAD, sample_o};
		else if (avs_address == `PADC_OFS_ANALOG)
			rdata_nxt = {RD_PAD, pipe_head};
	end

	always @(posedge core_clk)
	begin
		if (rst)
			avs_readdata <= 32'h0;
		else if (bus_take)
			avs_readdata <= rdata_nxt;
	end

	// ****************************************
	// Control register
	// ****************************************
	always @*
	begin
		ctrl_nxt = ctrl_r;
		if (ctrl_commit)
			ctrl_nxt = avs_writedata[3:0];
	end

	always @(posedge core_clk)
	begin
		if (rst)
			ctrl_r <= `PADC_CTRL_RST;
		else
			ctrl_r <= ctrl_nxt;
	end

	// ****************************************
	// Conversion pipeline
	// ****************************************
	// Error correction is folded into the delay: every code passes unaltered,
	// so all 2^DATA_W codes stay reachable. Sleep freezes every stage.
	assign pipe_adv  = !sleep_request;
	assign pipe_head = stage_bus[DATA_W-1:0];
	assign pipe_tail = stage_bus[DATA_W*LATENCY-1 -: DATA_W];

	genvar g;
	generate
		for (g = 0; g < LATENCY; g = g + 1)
		begin : g_stage
			if (g == 0)
			begin : g_first
				padc_stage
				#(
					.WIDTH   (DATA_W),
					.RST_VAL (`PADC_MIDSCALE)
				)
				u_padc_stage
				(
					.core_clk (core_clk),
					.rst      (rst),
					.adv      (pipe_adv),
					.d        (analog_code),
					.q        (stage_bus[DATA_W-1:0])
				);
			end
			else
			begin : g_next
				padc_stage
				#(
					.WIDTH   (DATA_W),
					.RST_VAL (`PADC_MIDSCALE)
				)
				u_padc_stage
				(
					.core_clk (core_clk),
					.rst      (rst),
					.adv      (pipe_adv),
					.d        (stage_bus[(g-1)*DATA_W +: DATA_W]),
					.q        (stage_bus[g*DATA_W +: DATA_W])
				);
			end
		end
	endgenerate

	// ****************************************
	// Fill count and output word
	// ****************************************
	// Leaving sleep restarts the count; the host drops words until valid rises
	assign fill_done = (fill_r == FILL_FULL);

	always @*
	begin
		fill_nxt = fill_r;
		if (sleep_request)
			fill_nxt = FILL_ZERO;
		else if (!fill_done)
			fill_nxt = fill_r + FILL_STEP;
	end

	always @(posedge core_clk)
	begin
		if (rst)
			fill_r <= FILL_ZERO;
		else
			fill_r <= fill_nxt;
	end

	// fifth edge after the sample, msb in bit DATA_W-1
	always @(posedge core_clk)
	begin
		if (rst)
			sample_o <= CODE_MID;
		else if (pipe_adv)
			sample_o <= pipe_tail;
	end

	// Valid drops at once in sleep, so no stale word is flagged as fresh
	always @(posedge core_clk)
	begin
		if (rst)
			sample_valid <= 1'b0;
		else if (sleep_request)
			sample_valid <= 1'b0;
		else
			sample_valid <= fill_done;
	end

	// ****************************************
	// Pin mirrors
	// ****************************************
	always @(posedge core_clk)
	begin
		if (rst)
			powered_down <= 1'b0;
		else
			powered_down <= sleep_request;
	end

	always @(posedge core_clk)
	begin
		if (rst)
			span_2v <= 1'b1;
		else
			span_2v <= input_span_select;
	end

	always @(posedge core_clk)
	begin
		if (rst)
			ref_external <= 1'b1;
		else
			ref_external <= reference_source_select;
	end

	// Output enable is low while the pins are driven
	always @(posedge core_clk)
	begin
		if (rst)
			sample_oe_n <= {DATA_W{1'b1}};
		else
			sample_oe_n <= {DATA_W{output_tristate_n}};
	end

endmodule

// ****************************************
// Pipeline stage
// ****************************************
// One register of the delay line; holds its word while adv is low
module padc_stage
#(
	parameter WIDTH   = `PADC_DATA_W,
	parameter RST_VAL = `PADC_MIDSCALE
)
(
	input  wire             core_clk,
	input  wire             rst,
	input  wire             adv,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	localparam [WIDTH-1:0] RST_Q = RST_VAL;

	always @(posedge core_clk)
	begin
		if (rst)
			q <= RST_Q;
		else if (adv)
			q <= d;
	end

endmodule
`default_nettype wire

// ==== tb/padc_monitor.sv ====
// Purpose: Port assertions for padc_core
// Assumes: One convert clock, rst synchronous
// Notes:   Output lags the sampling edge by six sampled edges
`timescale 1ns/100ps
`default_nettype none
module padc_monitor(
	input wire logic        core_clk, rst, avs_read, avs_write, avs_waitrequest,
	input wire logic        sample_valid, powered_down, span_2v, ref_external,
	input wire logic [9:0]  analog_code, sample_o, sample_oe_n,
	input wire logic [3:0]  avs_address, avs_byteenable,
	input wire logic [31:0] avs_writedata);
	logic [3:0] wd_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_ctrl_wr;
		avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
	endsequence
	// Held write value, so late checks see the word that was taken
	always @(posedge core_clk)
		if (avs_write && !avs_waitrequest && avs_address == 4'h0) wd_r <= avs_writedata[3:0];
	a_oe_mirror: assert property (s_ctrl_wr |-> ##[1:2] sample_oe_n == {10{wd_r[0]}})
		else $error("oe mirror");
	a_sleep_mirror: assert property (s_ctrl_wr |-> ##[1:2] powered_down == wd_r[1])
		else $error("sleep mirror");
	a_span_mirror: assert property (s_ctrl_wr |-> ##[1:2] span_2v == wd_r[2])
		else $error("span mirror");
	a_ref_mirror: assert property (s_ctrl_wr |-> ##[1:2] ref_external == wd_r[3])
		else $error("ref mirror");
	a_pipe_latency: assert property (sample_valid && $past(sample_valid, 6)
		|-> sample_o == $past(analog_code, 6)) else $error("latency");
	a_sleep_frozen: assert property (powered_down && $past(powered_down) |-> $stable(sample_o))
		else $error("sleep not frozen");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait");
	a_answer_bound: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
		else $error("no answer");
	a_reset_vals: assert property ($past(rst) |-> span_2v && ref_external
		&& sample_o == 10'h200) else $error("reset values");
endmodule
`default_nettype wire

// ==== tb/padc_host.sv ====
// Purpose: Host that feeds a code ramp and captures words
// Assumes: Ramp steps one code per clock; the bench ends long before it wraps
// Notes:   Words are kept only while the pipe is full
`timescale 1ns/100ps
`default_nettype none
module padc_host(
	input wire logic  core_clk,
	input wire logic  [9:0] sample_o,
	input wire logic  sample_valid,
	output logic      [9:0] analog_code = 10'h000,
	output logic      [9:0] last_word);
	always @(posedge core_clk)
	begin
		analog_code <= analog_code + 10'h001;
		if (sample_valid) last_word <= sample_o;
	end
endmodule
`default_nettype wire

// ==== tb/tb_padc_core.sv ====
// Purpose: Self-checking bench for padc_core
// Assumes: Avalon master holds until waitrequest low
// Notes:   Host ramp makes the expected word code minus six
`timescale 1ns/100ps
`default_nettype none
module tb_padc_core;
	logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, sample_valid, powered_down, span_2v, ref_external;
	logic [9:0] analog_code, sample_o, sample_oe_n, held;
	int n_fail = 0, n_checks = 0, cyc = 0;
	padc_core u_padc_core(.core_clk(core_clk), .rst(rst), .analog_code(analog_code),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_o(sample_o),
		.sample_oe_n(sample_oe_n), .sample_valid(sample_valid),
		.powered_down(powered_down), .span_2v(span_2v), .ref_external(ref_external));
	padc_host u_padc_host(.core_clk(core_clk), .sample_o(sample_o),
		.sample_valid(sample_valid), .analog_code(analog_code), .last_word());
	initial forever #25 core_clk = ~core_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end
	endtask
	task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int t;
		@(posedge core_clk);
		avs_address <= a; avs_writedata <= d; avs_write <= wr; avs_read <= !wr;
		t = 0;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0 && ++t < 20);
		rd = avs_readdata;
		avs_read <= 1'b0; avs_write <= 1'b0;
	endtask
	task close_out;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge core_clk)
		if (++cyc == 3000) begin n_fail++; close_out; end
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		acc(0, 4'h0, 0); chk(rd, 32'hC);
		chk({sample_oe_n, span_2v, ref_external}, 12'h003);
		repeat (12) @(posedge core_clk);
		@(negedge core_clk); chk(sample_o, analog_code - 10'h006);
		$display("reset and latency done");
		for (int v = 0; v < 16; v++)
		begin
			acc(1, 4'h0, v); repeat (2) @(posedge core_clk);
			chk({sample_oe_n, powered_down, span_2v, ref_external}, {{10{v[0]}}, v[1], v[2], v[3]});
		end
		acc(1, 4'h0, 32'hE); repeat (3) @(posedge core_clk);
		@(negedge core_clk); held = sample_o;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk); chk(sample_o, held);
		acc(0, 4'h4, 0); chk(rd & 32'h6, 32'h2);
		acc(1, 4'h0, 32'hC); repeat (14) @(posedge core_clk);
		@(negedge core_clk); chk(sample_o, analog_code - 10'h006);
		acc(0, 4'h4, 0); chk(rd & 32'h6, 32'h4);
		acc(0, 4'h2, 0); chk(rd, 32'hDEADBEEF);
		$display("control and status done");
		close_out;
	end
endmodule
bind padc_core padc_monitor u_padc_monitor(.*);
`default_nettype wire
